// ==== rtl/dim_mode_regs.v ====
/*
  identification, device type, vendor test and calibration default-reset
  mode registers of a low-power dram channel.
  identity and type values are parameters, write-only registers read as zero.
  assumes mode register read/write commands arrive already decoded as
  one-cycle strobes with address and operand, synchronous to clk_in.
  assumes the calibration strap is stable from power-up onward.
*/
// Function
// - address 05h reads a fixed eight-bit maker code that writes cannot change.
// - address 06h reads a fixed eight-bit first revision code for the silicon version.
// - address 07h reads a fixed eight-bit second revision code coded like the first.
// - address 08h bits 1:0 report type, 00 sixteen-prefetch and 01 low output supply.
// - address 08h bits 5:2 report density, 0000..0110 for 4..32 Gb and 1100 for 2 Gb.
// - address 08h bits 7:6 report width, 00 x16 and 01 x8, and the register is read-only.
// - address 0Ah bit 0 is write-only and writing 1 returns calibration to defaults.
// - a grounded calibration pin means default calibration only, and commands are ignored.
// - with the pin on the reference resistor, calibration commands and default reset work.
// - a read drives the eight register bits on the low data lines, reserved and unused as zero.
`timescale 1ns/1ps
`default_nettype none

`include "dim_consts.vh"

module dim_mode_regs #(
  parameter [7:0] MAKER_CODE   = `DIM_MAKER_DEFAULT,
  parameter [7:0] REV_FIRST    = `DIM_REV_FIRST_DEFAULT,
  parameter [7:0] REV_SECOND   = `DIM_REV_SECOND_DEFAULT,
  parameter [1:0] TYPE_CODE    = `DIM_TYPE_LOW_VDDQ,
  parameter [3:0] DENSITY_CODE = `DIM_DENS_32GB,
  parameter [1:0] WIDTH_CODE   = `DIM_WIDTH_X16,
  parameter       DQ_WIDTH     = 16
) (
  // clock and reset
  input  wire                clk_in,
  input  wire                nrst_in,
  // mode register command strobes
  input  wire                mr_write_in,
  input  wire                mr_read_in,
  input  wire [5:0]          mode_register_address_in,
  input  wire [7:0]          register_operand_bits_in,
  // calibration pin strap, high when tied to the reference resistor
  input  wire                cal_pin_resistor_in,
  // calibration commands from the command decoder
  input  wire                cal_start_in,
  input  wire                cal_latch_in,
  // read data
  output reg  [DQ_WIDTH-1:0] dq_out,
  output reg                 dq_valid_out,
  output reg                 read_hit_out,
  // calibration control
  output reg                 cal_default_out,
  output reg                 cal_start_out,
  output reg                 cal_latch_out,
  output reg                 cal_capable_out,
  // vendor test visibility
  output reg  [7:0]          vendor_test_out,
  output reg                 vendor_test_bad_out
);

  // one-hot states of the default-reset pulse
  localparam ST_IDLE  = 2'b01;
  localparam ST_PULSE = 2'b10;
  // first count of a pulse, so the output stands for the full length
  localparam [3:0] PULSE_LOAD = `DIM_CAL_PULSE_CYCLES - 4'h1;
  // data lines above the register byte
  localparam UNUSED_DQ = DQ_WIDTH - 8;

  // device type register and its fields
  wire [1:0]          type_field;
  wire [3:0]          density_field;
  wire [1:0]          width_field;
  wire [7:0]          type_reg;
  // read selector result
  wire [7:0]          sel_data;
  wire                sel_hit;
  // decoded write strobes
  wire                wr_vendor;
  wire                wr_cal_reset;
  wire                cal_reset_req;
  // pulse sequencer
  reg  [1:0]          state;
  reg  [1:0]          next_state;
  reg  [3:0]          pulse_cnt;
  reg  [3:0]          next_pulse_cnt;
  // strap capture
  reg                 strap_taken;
  reg                 cal_capable;
  reg                 next_cal_capable;
  // next read data
  reg  [DQ_WIDTH-1:0] next_dq;
  reg                 next_dq_valid;
  reg                 next_read_hit;
  // next vendor test state
  reg  [7:0]          next_vendor_test;
  reg                 next_vendor_test_bad;
  // next calibration outputs
  reg                 next_cal_default;
  reg                 next_cal_start;
  reg                 next_cal_latch;
  reg                 next_cal_capable_out;

  // identity constants come only from parameters, never from registers
  assign type_field    = TYPE_CODE;
  assign density_field = DENSITY_CODE;
  assign width_field   = WIDTH_CODE;
  assign type_reg      = {width_field, density_field, type_field};

  // plain address compare shared by every write decode
  function is_addr;
    input [5:0] a;
    input [5:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // upper data lines stay zero so a wide bus never shows stale bits
  function [DQ_WIDTH-1:0] place_low_byte;
    input [7:0] b;
    begin
      place_low_byte = {{UNUSED_DQ{1'b0}}, b};
    end
  endfunction

  // before the strap is taken no active command may slip through
  function cal_gate;
    input cmd;
    input capable;
    input taken;
    begin
      cal_gate = cmd & capable & taken;
    end
  endfunction

  // only the write-only registers decode writes; ids have no storage
  assign wr_vendor     = mr_write_in &
                         is_addr(mode_register_address_in, `DIM_ADDR_VENDOR_TEST);
  assign wr_cal_reset  = mr_write_in &
                         is_addr(mode_register_address_in, `DIM_ADDR_CAL_RESET);
  assign cal_reset_req = wr_cal_reset &
                         register_operand_bits_in[`DIM_CAL_DEFAULT_BIT];

  dim_read_mux u_read_mux (
    .addr_in       (mode_register_address_in),
    .maker_in      (MAKER_CODE),
    .rev_first_in  (REV_FIRST),
    .rev_second_in (REV_SECOND),
    .type_in       (type_reg),
    .data_out      (sel_data),
    .hit_out       (sel_hit)
  );

  // read data: register bits on the low byte, everything else zero
  always @* begin
    if (mr_read_in) begin
      next_dq = place_low_byte(sel_data);
    end else begin
      next_dq = {DQ_WIDTH{1'b0}};
    end
  end

  // an unmapped address still answers, with data zero and no hit
  always @* begin
    next_dq_valid = mr_read_in;
    next_read_hit = mr_read_in & sel_hit;
  end

  // registered so the data lines never glitch with the address decode
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dq_out <= {DQ_WIDTH{1'b0}};
    end else begin
      dq_out <= next_dq;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dq_valid_out <= 1'b0;
      read_hit_out <= 1'b0;
    end else begin
      dq_valid_out <= next_dq_valid;
      read_hit_out <= next_read_hit;
    end
  end

  // strap is caught once after reset release; the pin must not change later
  always @* begin
    next_cal_capable = cal_capable;
    if (!strap_taken) begin
      next_cal_capable = cal_pin_resistor_in;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_taken <= 1'b0;
      cal_capable <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
      cal_capable <= next_cal_capable;
    end
  end

  // vendor test register holds the last write; nonzero is flagged, not refused
  always @* begin
    next_vendor_test     = vendor_test_out;
    next_vendor_test_bad = vendor_test_bad_out;
    if (wr_vendor) begin
      next_vendor_test     = register_operand_bits_in;
      next_vendor_test_bad = (register_operand_bits_in != `DIM_VENDOR_TEST_SAFE);
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vendor_test_out     <= `DIM_VENDOR_TEST_SAFE;
      vendor_test_bad_out <= 1'b0;
    end else begin
      vendor_test_out     <= next_vendor_test;
      vendor_test_bad_out <= next_vendor_test_bad;
    end
  end

  // default-reset pulse; a request while one runs is dropped, not queued
  always @* begin
    next_state     = state;
    next_pulse_cnt = pulse_cnt;
    case (state)
      ST_IDLE: begin
        if (cal_reset_req) begin
          next_state     = ST_PULSE;
          next_pulse_cnt = PULSE_LOAD;
        end
      end
      ST_PULSE: begin
        if (pulse_cnt == 4'h0) begin
          next_state = ST_IDLE;
        end else begin
          next_pulse_cnt = pulse_cnt - 4'h1;
        end
      end
      default: begin
        next_state     = ST_IDLE;
        next_pulse_cnt = 4'h0;
      end
    endcase
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state     <= ST_IDLE;
      pulse_cnt <= 4'h0;
    end else begin
      state     <= next_state;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // default reset follows the sequencer whatever the strap says
  always @* begin
    next_cal_default = (next_state == ST_PULSE);
  end

  // grounded pin blocks active commands only
  always @* begin
    next_cal_start       = cal_gate(cal_start_in, cal_capable, strap_taken);
    next_cal_latch       = cal_gate(cal_latch_in, cal_capable, strap_taken);
    next_cal_capable_out = cal_capable;
  end

  // registered so the pulse length is exact in whole clock cycles
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cal_default_out <= 1'b0;
    end else begin
      cal_default_out <= next_cal_default;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cal_start_out   <= 1'b0;
      cal_latch_out   <= 1'b0;
      cal_capable_out <= 1'b0;
    end else begin
      cal_start_out   <= next_cal_start;
      cal_latch_out   <= next_cal_latch;
      cal_capable_out <= next_cal_capable_out;
    end
  end

  // no storage exists for ids, so writes to 05h..08h have no effect

endmodule

`default_nettype wire

// ==== rtl/dim_consts.vh ====
/*
  constants for the identification and calibration-reset mode register bank:
  register addresses, field positions, identity defaults, cycle counts.
  assumes inclusion by bare name from design files under rtl/.
*/
`ifndef DIM_CONSTS_VH
`define DIM_CONSTS_VH

// mode register addresses (6-bit)
`define DIM_ADDR_MAKER        6'h05
`define DIM_ADDR_REV_FIRST    6'h06
`define DIM_ADDR_REV_SECOND   6'h07
`define DIM_ADDR_TYPE         6'h08
`define DIM_ADDR_VENDOR_TEST  6'h09
`define DIM_ADDR_CAL_RESET    6'h0a

// device type register fields
`define DIM_TYPE_LSB          0
`define DIM_TYPE_MSB          1
`define DIM_DENS_LSB          2
`define DIM_DENS_MSB          5
`define DIM_WIDTH_LSB         6
`define DIM_WIDTH_MSB         7

// type codes
`define DIM_TYPE_S16          2'h0
`define DIM_TYPE_LOW_VDDQ     2'h1
// density codes
`define DIM_DENS_4GB          4'h0
`define DIM_DENS_32GB         4'h6
`define DIM_DENS_2GB          4'hc
// width codes
`define DIM_WIDTH_X16         2'h0
`define DIM_WIDTH_X8          2'h1

// calibration reset register field
`define DIM_CAL_DEFAULT_BIT   0
// vendor test register advised value
`define DIM_VENDOR_TEST_SAFE  8'h00

// identity defaults, values arbitrary
`define DIM_MAKER_DEFAULT     8'h5a
`define DIM_REV_FIRST_DEFAULT 8'h01
`define DIM_REV_SECOND_DEFAULT 8'h02

// calibration default pulse length in clock cycles
`define DIM_CAL_PULSE_CYCLES  4'h4

`endif

// ==== rtl/dim_read_mux.v ====
/*
  read data selector: maps a mode register address to its eight-bit value.
  assumes the identification values are constant inputs from the top level.
*/
`timescale 1ns/1ps
`default_nettype none

module dim_read_mux (
  // selection
  input  wire [5:0] addr_in,
  // register contents
  input  wire [7:0] maker_in,
  input  wire [7:0] rev_first_in,
  input  wire [7:0] rev_second_in,
  input  wire [7:0] type_in,
  // result
  output reg  [7:0] data_out,
  output reg        hit_out
);

`include "dim_consts.vh"

  always @* begin
    data_out = 8'h00;
    hit_out  = 1'b1;
    case (addr_in)
      `DIM_ADDR_MAKER:      data_out = maker_in;
      `DIM_ADDR_REV_FIRST:  data_out = rev_first_in;
      `DIM_ADDR_REV_SECOND: data_out = rev_second_in;
      `DIM_ADDR_TYPE:       data_out = type_in;
      // write-only registers read back as zero
      `DIM_ADDR_VENDOR_TEST: data_out = 8'h00;
      `DIM_ADDR_CAL_RESET:   data_out = 8'h00;
      default: begin
        hit_out  = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ==== verification/dim_props.sv ====
/* checker for the id and calibration-reset mode registers.
   assumes it is bound to dim_mode_regs and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module dim_props #(
  parameter [7:0] MAKER_CODE   = 8'h00,
  parameter [7:0] REV_FIRST    = 8'h00,
  parameter [7:0] REV_SECOND   = 8'h00,
  parameter [1:0] TYPE_CODE    = 2'h0,
  parameter [3:0] DENSITY_CODE = 4'h0,
  parameter [1:0] WIDTH_CODE   = 2'h0,
  parameter       DQ_WIDTH     = 16
) (
  // command side
  input wire logic                clk_in,
  input wire logic                nrst_in,
  input wire logic                mr_write_in,
  input wire logic                mr_read_in,
  input wire logic [5:0]          mode_register_address_in,
  input wire logic [7:0]          register_operand_bits_in,
  input wire logic                cal_pin_resistor_in,
  input wire logic                cal_start_in,
  // device side
  input wire logic [DQ_WIDTH-1:0] dq_out,
  input wire logic                dq_valid_out,
  input wire logic                read_hit_out,
  input wire logic                cal_default_out,
  input wire logic                cal_start_out,
  input wire logic                cal_latch_out,
  input wire logic                cal_capable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_rd(a);
    mr_read_in && mode_register_address_in == a;
  endsequence
  sequence s_cal_pulse;
    cal_default_out [*4] ##1 !cal_default_out;
  endsequence
  a_read_answer: assert property (mr_read_in |=> dq_valid_out)
    else $error("read gave no answer");
  a_idle_quiet: assert property (!dq_valid_out |-> dq_out == '0)
    else $error("data lines busy while idle");
  a_upper_zero: assert property (dq_valid_out |-> dq_out[DQ_WIDTH-1:8] == '0)
    else $error("unused data lines not zero");
  a_maker_value: assert property (s_rd(6'h05) |=> dq_out[7:0] == MAKER_CODE)
    else $error("maker code wrong");
  a_rev_value: assert property (s_rd(6'h06) |=> dq_out[7:0] == REV_FIRST)
    else $error("revision code wrong");
  a_rev_second: assert property (s_rd(6'h07) |=> dq_out[7:0] == REV_SECOND)
    else $error("second revision code wrong");
  a_type_fields: assert property (s_rd(6'h08) |=>
    dq_out[7:0] == {WIDTH_CODE, DENSITY_CODE, TYPE_CODE}) else $error("type register wrong");
  a_wo_zero: assert property ((s_rd(6'h09) or s_rd(6'h0a)) |=>
    dq_out == '0 && read_hit_out) else $error("write-only register read back nonzero");
  a_cal_pulse: assert property (cal_pin_resistor_in && mr_write_in && !cal_default_out
    && mode_register_address_in == 6'h0a && register_operand_bits_in[0] |=> s_cal_pulse)
    else $error("default calibration pulse wrong");
  a_cal_ignored: assert property (!cal_pin_resistor_in |-> !cal_start_out && !cal_latch_out)
    else $error("calibration passed with pin grounded");
  a_cal_pass: assert property (cal_capable_out && cal_start_in |=> cal_start_out)
    else $error("calibration start lost");
endmodule
bind dim_mode_regs dim_props #(.MAKER_CODE(MAKER_CODE), .REV_FIRST(REV_FIRST),
  .REV_SECOND(REV_SECOND),
  .TYPE_CODE(TYPE_CODE), .DENSITY_CODE(DENSITY_CODE), .WIDTH_CODE(WIDTH_CODE),
  .DQ_WIDTH(DQ_WIDTH)) i_dim_props (.clk_in, .nrst_in, .mr_write_in, .mr_read_in,
  .mode_register_address_in, .register_operand_bits_in, .cal_pin_resistor_in, .cal_start_in,
  .dq_out, .dq_valid_out, .read_hit_out, .cal_default_out, .cal_start_out, .cal_latch_out,
  .cal_capable_out);
`default_nettype wire

// ==== verification/dim_ctrl_model.sv ====
/* memory controller model issuing mode register and calibration commands.
   assumes one clock shared with the device. */
`timescale 1ns/1ps
`default_nettype none
module dim_ctrl_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] dq_in,
  output var  logic        mw_out,
  output var  logic        mr_out,
  output var  logic [5:0]  ad_out,
  output var  logic [7:0]  op_out,
  output var  logic        cs_out,
  output var  logic        cl_out
);
  initial {mw_out, mr_out, ad_out, op_out, cs_out, cl_out} = '0;
  // released lines inverted so stale values never look valid
  task wr(input [5:0] a, input [7:0] d);
    @(posedge clk_in);
    mw_out <= 1'b1; ad_out <= a; op_out <= d;
    @(posedge clk_in);
    mw_out <= 1'b0; ad_out <= ~a; op_out <= ~d;
    #1;
  endtask
  task rd(input [5:0] a, output [7:0] d);
    @(posedge clk_in);
    mr_out <= 1'b1; ad_out <= a;
    @(posedge clk_in);
    mr_out <= 1'b0; ad_out <= ~a;
    #1 d = dq_in[7:0];
  endtask
  task cal(input s, input l);
    @(posedge clk_in);
    cs_out <= s; cl_out <= l;
    @(posedge clk_in);
    cs_out <= 1'b0; cl_out <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/* self-checking bench for the id and calibration-reset mode registers.
   assumes the design and its bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  localparam [7:0] MK = 8'h3c; // arbitrary identity value
  localparam [7:0] R1 = 8'h11; // arbitrary identity value
  localparam [7:0] R2 = 8'h12; // arbitrary identity value
  reg clk_in = 1'b0, nrst_in = 1'b0, strap = 1'b1;
  wire mw, mr, cs, cl, dv, hit, cdef, cso, clo, cap, vbad;
  wire [5:0] ad;
  wire [7:0] op, vt;
  wire [15:0] dq;
  integer failures = 0, total_checks = 0, cyc = 0, i, n;
  reg [7:0] d;
  reg [7:0] et [0:7];
  initial forever #4 clk_in = ~clk_in;
  dim_ctrl_model ctl (.clk_in(clk_in), .dq_in(dq), .mw_out(mw), .mr_out(mr), .ad_out(ad),
    .op_out(op), .cs_out(cs), .cl_out(cl));
  // 2 Gb x8 low-supply boundary codes
  dim_mode_regs #(.MAKER_CODE(MK), .REV_FIRST(R1), .REV_SECOND(R2), .TYPE_CODE(2'h1),
    .DENSITY_CODE(4'hc), .WIDTH_CODE(2'h1)) i_dim_mode_regs (.clk_in(clk_in),
    .nrst_in(nrst_in), .mr_write_in(mw), .mr_read_in(mr), .mode_register_address_in(ad),
    .register_operand_bits_in(op), .cal_pin_resistor_in(strap), .cal_start_in(cs),
    .cal_latch_in(cl), .dq_out(dq), .dq_valid_out(dv), .read_hit_out(hit),
    .cal_default_out(cdef), .cal_start_out(cso), .cal_latch_out(clo),
    .cal_capable_out(cap), .vendor_test_out(vt), .vendor_test_bad_out(vbad));
  task finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      finish_test;
    end
  end
  task reset(input s);
    @(posedge clk_in);
    nrst_in <= 1'b0; strap <= s;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
  endtask
  task read_all;
    for (i = 0; i < 8; i++) begin
      ctl.rd(6'h04 + i, d);
      `CHK("read", et[i], d)
      `CHK("read valid", 1'b1, dv)
      `CHK("read hit", (i > 0 && i < 7), hit)
    end
  endtask
  task pulse_len(input [7:0] v);
    ctl.wr(6'h0a, v);
    n = 0;
    repeat (8) begin
      n += (cdef === 1'b1);
      @(posedge clk_in); #1;
    end
  endtask
  initial begin
    et = '{8'h00, MK, R1, R2, {2'h1, 4'hc, 2'h1}, 8'h00, 8'h00, 8'h00};
    reset(1'b1);
    read_all;
    $display("id test done");
    for (i = 1; i < 5; i++) ctl.wr(6'h04 + i, 8'hff);
    read_all;
    $display("read-only test done");
    ctl.wr(6'h09, 8'h00);
    `CHK("vendor flag", 1'b0, vbad)
    ctl.wr(6'h09, 8'h5a);
    `CHK("vendor value", 8'h5a, vt)
    `CHK("vendor flag", 1'b1, vbad)
    $display("vendor test done");
    pulse_len(8'h01);
    `CHK("default pulse", 4, n)
    pulse_len(8'hfe);
    `CHK("default pulse", 0, n)
    ctl.cal(1'b1, 1'b0);
    `CHK("cal start", 1'b1, cso)
    ctl.cal(1'b0, 1'b1);
    `CHK("cal latch", 1'b1, clo)
    `CHK("capable", 1'b1, cap)
    $display("calibration test done");
    reset(1'b0);
    ctl.cal(1'b1, 1'b1);
    `CHK("cal start", 1'b0, cso)
    `CHK("cal latch", 1'b0, clo)
    `CHK("capable", 1'b0, cap)
    $display("grounded pin test done");
    finish_test;
  end
endmodule
`default_nettype wire
